//--- logic/jib_top.sv
// Test access port: instruction decode, data registers, pad and flash controls
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns

module jib_top #(
	parameter int           BSR_LEN  = 8,            // Boundary cells
	parameter logic [31:0]  ID_VALUE = 32'h0000_0001 // Arbitrary identity value
) (
	input  wire logic                 ref_clk_in,       // 100 MHz system clock
	input  wire logic                 rst_n_in,         // Power-on reset, sync, low
	input  jib_pkg::jib_tap_pins_t    tap_pins_in,      // TCLK, TMS, TDI levels
	input  wire logic                 trst_n_in,        // Test reset, active low
	output logic                      tdo_out,          // Test data out
	output logic                      tdo_oe_out,       // TDO driven when high
	input  wire logic [BSR_LEN-1:0]   bsr_pins_in,      // Pin levels and core outputs
	output logic      [BSR_LEN-1:0]   bsr_update_out,   // Boundary update cells
	output jib_pkg::jib_pad_ctrl_t    pad_ctrl_out,     // Core reset, high-Z, force
	output logic                      leakage_out,      // Pad leakage test
	output logic      [2:0]           test_ctrl_out,    // Test-control hold
	output logic      [6:0]           flash_erase_clock_divider_out, // Erase divider
	output logic                      flash_erase_req_out,  // Erase request
	output logic                      low_power_ok_out, // Stop mode permitted
	input  wire logic                 wb_cyc_in,        // Wishbone cycle
	input  wire logic                 wb_stb_in,        // Wishbone strobe
	input  wire logic                 wb_we_in,         // Wishbone write
	input  wire logic [7:0]           wb_adr_in,        // Byte address
	input  wire logic [3:0]           wb_sel_in,        // Byte lane select
	input  wire logic [31:0]          wb_dat_in,        // Write data
	output logic      [31:0]          wb_dat_out,       // Read data
	output logic                      wb_ack_out        // Acknowledge
);
	import jib_pkg::*;

	if (BSR_LEN < 1) begin : g_len_chk
		$error("jib_top: BSR_LEN must be at least 1");
	end

	// ****************************************
	// Input blocking and TCLK edges
	// ****************************************
	jib_tap_pins_t  pins_eff;
	logic           tclk_q_reg;
	logic           tclk_rise;
	logic           tclk_fall;
	logic           tap_rst_n;
	logic           leak_reg;

	// Once leakage is up, TCLK, TMS, TDI all read one, so no more edges
	assign pins_eff  = leak_reg ? PINS_BLOCKED : tap_pins_in;
	// Test reset is sampled; taken the cycle it is seen low
	assign tap_rst_n = rst_n_in & trst_n_in;
	assign tclk_rise = pins_eff.tclk & ~tclk_q_reg;
	assign tclk_fall = ~pins_eff.tclk & tclk_q_reg;

	always_ff @(posedge ref_clk_in) begin
		if (!tap_rst_n) begin
			// Idle-high TCLK at release must not fake a rising edge
			tclk_q_reg <= 1'b1;
		end else begin
			tclk_q_reg <= pins_eff.tclk;
		end
	end

	// ****************************************
	// Controller
	// ****************************************
	jib_tap_state_t tap_state;

	jib_tap_fsm u_fsm (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (tap_rst_n),
		.adv_in     (tclk_rise),
		.tms_in     (pins_eff.tms),
		.state_out  (tap_state)
	);

	logic in_tlr;
	logic in_rti;
	logic in_shf_ir;
	logic in_shf_dr;
	logic in_upd_ir;
	logic in_upd_dr;

	assign in_tlr    = (tap_state == TLR);
	assign in_rti    = (tap_state == RTI);
	assign in_shf_ir = (tap_state == SHF_IR);
	assign in_shf_dr = (tap_state == SHF_DR);
	assign in_upd_ir = (tap_state == UPD_IR);
	assign in_upd_dr = (tap_state == UPD_DR);

	// ****************************************
	// Instruction register
	// ****************************************
	logic [IR_W-1:0] ir_par;
	jib_instr_t      instr_reg;

	jib_shreg #(.W(IR_W), .RST_VAL(IR_CAPTURE)) u_ir (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (tap_rst_n),
		.load_in    (tclk_rise & (tap_state == CAP_IR)),
		.cap_in     (IR_CAPTURE),
		.shift_in   (tclk_rise & in_shf_ir),
		.sin_in     (pins_eff.tdi),
		.par_out    (ir_par)
	);

	always_ff @(posedge ref_clk_in) begin
		if (!tap_rst_n || in_tlr) begin
			instr_reg <= INS_IDCODE;
		end else if (tclk_fall && in_upd_ir) begin
			instr_reg <= ir_par;
		end
	end

	// ****************************************
	// Instruction decode
	// ****************************************
	jib_dr_sel_t dr_sel;
	logic        is_extest;
	logic        is_sample;
	logic        is_highz;
	logic        is_clamp;
	logic        is_leak;
	logic        is_tc;
	logic        is_lock;
	logic        cap_dr;
	logic        shf_dr;
	logic        upd_dr;

	assign dr_sel    = jib_sel_f(instr_reg);
	assign is_extest = (instr_reg == INS_EXTEST);
	assign is_sample = (instr_reg == INS_SAMPLE);
	assign is_highz  = (instr_reg == INS_HIGHZ);
	assign is_clamp  = (instr_reg == INS_CLAMP);
	assign is_leak   = (instr_reg == INS_LEAKAGE);
	assign is_tc     = (instr_reg == INS_TESTCTL);
	assign is_lock   = (instr_reg == INS_LOCKOUT);
	// Capture on the rise leaving capture-DR, i.e. first rise after entry
	assign cap_dr    = tclk_rise & (tap_state == CAP_DR);
	assign shf_dr    = tclk_rise & in_shf_dr;
	assign upd_dr    = tclk_fall & in_upd_dr;

	// ****************************************
	// Data registers
	// ****************************************
	logic               byp_par;
	logic [ID_W-1:0]    id_par;
	logic [BSR_LEN-1:0] bsr_par;
	logic [TC_W-1:0]    tc_par;
	logic [DIV_W-1:0]   div_par;
	logic [ID_W-1:0]    id_cap;

	assign id_cap = {ID_VALUE[ID_W-1:1], ID_LSB};

	jib_shreg #(.W(1), .RST_VAL(BYP_CAP)) u_byp (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (tap_rst_n),
		.load_in    (cap_dr & (dr_sel == DR_BYP)),
		.cap_in     (BYP_CAP),
		.shift_in   (shf_dr & (dr_sel == DR_BYP)),
		.sin_in     (pins_eff.tdi),
		.par_out    (byp_par)
	);

	jib_shreg #(.W(ID_W), .RST_VAL('0)) u_id (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (tap_rst_n),
		.load_in    (cap_dr & (dr_sel == DR_ID)),
		.cap_in     (id_cap),
		.shift_in   (shf_dr & (dr_sel == DR_ID)),
		.sin_in     (pins_eff.tdi),
		.par_out    (id_par)
	);

	// Capture only reads the pins; nothing here feeds back into the core
	jib_shreg #(.W(BSR_LEN), .RST_VAL('0)) u_bsr (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (tap_rst_n),
		.load_in    (cap_dr & (dr_sel == DR_BSR)),
		.cap_in     (bsr_pins_in),
		.shift_in   (shf_dr & (dr_sel == DR_BSR)),
		.sin_in     (pins_eff.tdi),
		.par_out    (bsr_par)
	);

	jib_shreg #(.W(TC_W), .RST_VAL(TC_RST)) u_tc (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (tap_rst_n),
		.load_in    (cap_dr & (dr_sel == DR_TC)),
		.cap_in     (test_ctrl_out),
		.shift_in   (shf_dr & (dr_sel == DR_TC)),
		.sin_in     (pins_eff.tdi),
		.par_out    (tc_par)
	);

	jib_shreg #(.W(DIV_W), .RST_VAL(DIV_RST)) u_div (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (tap_rst_n),
		.load_in    (cap_dr & (dr_sel == DR_DIV)),
		.cap_in     (flash_erase_clock_divider_out),
		.shift_in   (shf_dr & (dr_sel == DR_DIV)),
		.sin_in     (pins_eff.tdi),
		.par_out    (div_par)
	);

	// ****************************************
	// Update and hold registers
	// ****************************************
	// Held across TAP resets; only power-on reset clears them
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			bsr_update_out <= '0;
		end else if (upd_dr && (is_sample || is_extest)) begin
			bsr_update_out <= bsr_par;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			test_ctrl_out <= TC_RST;
		end else if (upd_dr && is_tc) begin
			test_ctrl_out <= tc_par;
		end
	end

	// Tester must load this before idling; the erase reads it as it stands
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			flash_erase_clock_divider_out <= DIV_RST;
		end else if (upd_dr && is_lock) begin
			flash_erase_clock_divider_out <= div_par;
		end
	end

	// ****************************************
	// Serial output
	// ****************************************
	logic dr_lsb;

	always_comb begin
		dr_lsb = byp_par;
		unique case (dr_sel)
			DR_ID:   dr_lsb = id_par[0];
			DR_BSR:  dr_lsb = bsr_par[0];
			DR_TC:   dr_lsb = tc_par[0];
			DR_DIV:  dr_lsb = div_par[0];
			DR_BYP:  dr_lsb = byp_par;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!tap_rst_n) begin
			tdo_out    <= 1'b0;
			tdo_oe_out <= 1'b0;
		end else if (tclk_fall) begin
			tdo_out    <= in_shf_ir ? ir_par[0] : dr_lsb;
			tdo_oe_out <= in_shf_ir | in_shf_dr;
		end
	end

	// ****************************************
	// Pad, leakage and flash controls
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (!tap_rst_n) begin
			leak_reg <= 1'b0;
		end else if (tclk_rise && in_upd_ir && !pins_eff.tms && is_leak) begin
			leak_reg <= 1'b1;
		end
	end

	assign leakage_out = leak_reg;

	always_ff @(posedge ref_clk_in) begin
		if (!tap_rst_n) begin
			pad_ctrl_out <= '0;
			flash_erase_req_out <= 1'b0;
		end else begin
			pad_ctrl_out.sys_reset    <= is_extest | is_highz | is_clamp;
			pad_ctrl_out.highz        <= is_highz | leak_reg;
			pad_ctrl_out.force_update <= is_extest | is_clamp;
			flash_erase_req_out       <= in_rti & is_lock;
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	logic        stop_req_reg;
	logic        wb_req;
	logic        wb_wr_ctrl;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign wb_req     = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign wb_wr_ctrl = wb_req & wb_we_in & wb_sel_in[0] & (wb_adr_in == OFS_CTRL);

	always_comb begin
		status_word = '0;
		status_word[ST_STATE_LSB +: 4]     = tap_state;
		status_word[ST_INSTR_LSB +: IR_W]  = instr_reg;
		status_word[ST_LEAK_BIT]           = leak_reg;
		status_word[ST_ERASE_BIT]          = flash_erase_req_out;
		status_word[ST_LPOK_BIT]           = low_power_ok_out;
		status_word[ST_TC_LSB +: TC_W]     = test_ctrl_out;
		status_word[ST_DIV_LSB +: DIV_W]   = flash_erase_clock_divider_out;
	end

	// Unmapped addresses still answer, with zero
	assign rd_mux = (wb_adr_in == OFS_CTRL)   ? {31'h0, stop_req_reg} :
	                (wb_adr_in == OFS_STATUS) ? status_word :
	                (wb_adr_in == OFS_IDCODE) ? id_cap : 32'h0;

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= '0;
		end else begin
			wb_ack_out <= wb_req;
			wb_dat_out <= wb_req ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			stop_req_reg <= CTRL_STOP_RST;
		end else if (wb_wr_ctrl) begin
			stop_req_reg <= wb_dat_in[CTRL_STOP_BIT];
		end
	end

	// Stop allowed only while the controller rests in test-logic-reset
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			low_power_ok_out <= 1'b0;
		end else begin
			low_power_ok_out <= stop_req_reg & in_tlr;
		end
	end
endmodule

//--- logic/jib_pkg.sv
// Shared constants, types and helpers of the test access port block
package jib_pkg;

	// ****************************************
	// Register widths and reset values
	// ****************************************
	localparam int IR_W  = 4;
	localparam int ID_W  = 32;
	localparam int TC_W  = 3;
	localparam int DIV_W = 7;

	typedef logic [IR_W-1:0] jib_instr_t;

	localparam jib_instr_t INS_EXTEST  = 4'h0;
	localparam jib_instr_t INS_IDCODE  = 4'h1;
	localparam jib_instr_t INS_SAMPLE  = 4'h2;
	localparam jib_instr_t INS_LEAKAGE = 4'h5;
	localparam jib_instr_t INS_TESTCTL = 4'h6;
	localparam jib_instr_t INS_HIGHZ   = 4'h9;
	localparam jib_instr_t INS_LOCKOUT = 4'hB;
	localparam jib_instr_t INS_CLAMP   = 4'hC;
	localparam jib_instr_t INS_BYPASS  = 4'hF;
	localparam jib_instr_t IR_CAPTURE  = 4'h1;

	localparam logic [TC_W-1:0]  TC_RST  = 3'h0;
	localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
	localparam logic             BYP_CAP = 1'h0;
	localparam logic             ID_LSB  = 1'h1;

	// ****************************************
	// Wishbone map and field positions
	// ****************************************
	localparam int             ADR_W        = 8;
	localparam logic [ADR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADR_W-1:0] OFS_IDCODE = 8'h08;
	localparam int             CTRL_STOP_BIT = 0;
	localparam int             ST_STATE_LSB  = 0;
	localparam int             ST_INSTR_LSB  = 4;
	localparam int             ST_LEAK_BIT   = 8;
	localparam int             ST_ERASE_BIT  = 9;
	localparam int             ST_LPOK_BIT   = 10;
	localparam int             ST_TC_LSB     = 12;
	localparam int             ST_DIV_LSB    = 16;
	localparam logic           CTRL_STOP_RST = 1'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} jib_tap_state_t;

	typedef enum logic [2:0] {DR_BYP, DR_ID, DR_BSR, DR_TC, DR_DIV} jib_dr_sel_t;

	typedef struct packed {
		logic tclk;
		logic tms;
		logic tdi;
	} jib_tap_pins_t;

	typedef struct packed {
		logic sys_reset;
		logic highz;
		logic force_update;
	} jib_pad_ctrl_t;

	localparam jib_tap_pins_t PINS_BLOCKED = 3'h7;

	// Instruction to data register; unknown codes fall to bypass
	function automatic jib_dr_sel_t jib_sel_f(input jib_instr_t ins);
		unique case (ins)
			INS_IDCODE:             jib_sel_f = DR_ID;
			INS_EXTEST, INS_SAMPLE: jib_sel_f = DR_BSR;
			INS_TESTCTL:            jib_sel_f = DR_TC;
			INS_LOCKOUT:            jib_sel_f = DR_DIV;
			default:                jib_sel_f = DR_BYP;
		endcase
	endfunction

endpackage

//--- logic/jib_shreg.sv
// Capture-and-shift register, LSB toward the serial output
`timescale 1ns/1ns
module jib_shreg #(
	parameter int         W       = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         ref_clk_in, // System clock
	input  wire logic         rst_n_in,   // Sync reset, active low
	input  wire logic         load_in,    // Parallel capture strobe
	input  wire logic [W-1:0] cap_in,     // Capture value
	input  wire logic         shift_in,   // Shift strobe
	input  wire logic         sin_in,     // Serial in at MSB
	output logic      [W-1:0] par_out     // Register contents
);
	// Refused at elaboration; a chain needs at least one cell
	if (W < 1) begin : g_w_chk
		$error("jib_shreg: W must be at least 1");
	end

	logic [W-1:0] sh_next;

	generate
		if (W == 1) begin : g_one
			assign sh_next = sin_in;
		end else begin : g_many
			assign sh_next = {sin_in, par_out[W-1:1]};
		end
	endgenerate

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			par_out <= RST_VAL;
		end else if (load_in) begin
			par_out <= cap_in;
		end else if (shift_in) begin
			par_out <= sh_next;
		end
	end
endmodule

//--- logic/jib_tap_fsm.sv
// Sixteen-state test access port controller
`timescale 1ns/1ns
module jib_tap_fsm (
	input  wire logic             ref_clk_in, // System clock
	input  wire logic             rst_n_in,   // TAP reset, active low
	input  wire logic             adv_in,     // TCLK rising-edge enable
	input  wire logic             tms_in,     // Mode select
	output jib_pkg::jib_tap_state_t state_out // Current state
);
	import jib_pkg::*;

	jib_tap_state_t state_next;

	always_comb begin
		state_next = state_out;
		unique case (state_out)
			TLR:    state_next = tms_in ? TLR    : RTI;
			RTI:    state_next = tms_in ? SEL_DR : RTI;
			SEL_DR: state_next = tms_in ? SEL_IR : CAP_DR;
			CAP_DR: state_next = tms_in ? EX1_DR : SHF_DR;
			SHF_DR: state_next = tms_in ? EX1_DR : SHF_DR;
			EX1_DR: state_next = tms_in ? UPD_DR : PAU_DR;
			PAU_DR: state_next = tms_in ? EX2_DR : PAU_DR;
			EX2_DR: state_next = tms_in ? UPD_DR : SHF_DR;
			UPD_DR: state_next = tms_in ? SEL_DR : RTI;
			SEL_IR: state_next = tms_in ? TLR    : CAP_IR;
			CAP_IR: state_next = tms_in ? EX1_IR : SHF_IR;
			SHF_IR: state_next = tms_in ? EX1_IR : SHF_IR;
			EX1_IR: state_next = tms_in ? UPD_IR : PAU_IR;
			PAU_IR: state_next = tms_in ? EX2_IR : PAU_IR;
			EX2_IR: state_next = tms_in ? UPD_IR : SHF_IR;
			UPD_IR: state_next = tms_in ? SEL_DR : RTI;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_out <= TLR;
		end else if (adv_in) begin
			state_out <= state_next;
		end
	end
endmodule

//--- test/jib_top_chk.sv
// Port-level assertions of the test access port
`timescale 1ns/1ns
module jib_top_chk #(
	parameter int BSR_LEN = 8 // Boundary cells
) (
	input  wire logic               ref_clk_in,     // Clock
	input  wire logic               rst_n_in,       // Reset, active low
	input  jib_pkg::jib_tap_pins_t  tap_pins_in,    // TAP pins
	input  wire logic               trst_n_in,      // Test reset
	input  wire logic               tdo_out,        // Test data out
	input  wire logic               tdo_oe_out,     // TDO enable
	input  wire logic [BSR_LEN-1:0] bsr_update_out, // Update cells
	input  wire logic               leakage_out,    // Leakage test
	input  wire logic [2:0]         test_ctrl_out,  // Test-control hold
	input  wire logic [6:0]         flash_erase_clock_divider_out, // Divider
	input  wire logic               flash_erase_req_out, // Erase request
	input  wire logic               low_power_ok_out,    // Stop permitted
	input  wire logic               wb_cyc_in,      // Cycle
	input  wire logic               wb_stb_in,      // Strobe
	input  wire logic               wb_ack_out      // Acknowledge
);
	import jib_pkg::*;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack late");
	AST_ACK_DROP: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held");
	// Trst may clear TDO while TCLK stands high, so those cycles are excused
	AST_TDO_FALL: assert property ($changed({tdo_out, tdo_oe_out}) && trst_n_in &&
		$past(trst_n_in) && $past(trst_n_in, 2) |-> !tap_pins_in.tclk) else $error("tdo moved");
	AST_UPD_FALL: assert property ($changed(bsr_update_out) |-> !tap_pins_in.tclk)
		else $error("update cells moved");
	AST_HOLD_FALL: assert property ($changed(test_ctrl_out) ||
		$changed(flash_erase_clock_divider_out) |-> !tap_pins_in.tclk) else $error("hold moved");
	AST_LEAK_RISE: assert property ($rose(leakage_out) |-> tap_pins_in.tclk)
		else $error("leakage off edge");
	AST_LEAK_HOLD: assert property (leakage_out && trst_n_in |=> leakage_out)
		else $error("leakage dropped");
	AST_LEAK_QUIET: assert property (leakage_out |-> !tdo_oe_out && !flash_erase_req_out)
		else $error("leakage not quiet");
	AST_TRST_CLR: assert property (!trst_n_in |-> ##[1:2]
		(!leakage_out && !tdo_oe_out && !flash_erase_req_out)) else $error("trst ignored");
	AST_LP_TLR: assert property (low_power_ok_out |->
		!tdo_oe_out && !flash_erase_req_out && !leakage_out) else $error("stop outside reset");
endmodule

//--- test/jib_tester.sv
// Boundary-scan tester model driving the test pins
`timescale 1ns/1ns
module jib_tester (
	input  wire logic              ref_clk_in, // System clock
	input  wire logic              tdo_in,     // Resolved TDO wire
	output jib_pkg::jib_tap_pins_t pins_out,   // TCLK, TMS, TDI
	output logic                   trst_n_out  // Test reset
);
	import jib_pkg::*;
	initial begin
		pins_out = PINS_BLOCKED;
		trst_n_out = 1'h1;
	end
	// ****************************************
	// Pin sequences
	// ****************************************
	// Three cycles a level, more than the edge detector needs
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		@(posedge ref_clk_in);
		pins_out <= {1'h0, tms, tdi};
		repeat (3) @(posedge ref_clk_in);
		tdo = tdo_in;
		pins_out <= {1'h1, tms, tdi};
		repeat (3) @(posedge ref_clk_in);
		pins_out <= PINS_BLOCKED; // Pull-ups once released, TCLK parked high
	endtask
	task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic b;
		dout = 32'h0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
		end
	endtask
	task automatic ir(input jib_instr_t ins, output logic [31:0] cap, input logic to_dr);
		logic b;
		step(1'h1, 1'h1, b);
		step(1'h1, 1'h1, b);
		step(1'h0, 1'h1, b);
		step(1'h0, 1'h1, b);
		scan(IR_W, 32'(ins), cap);
		step(1'h1, 1'h1, b);
		step(to_dr, 1'h1, b);
	endtask
	task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout,
		input logic from_sel);
		logic b;
		if (!from_sel) step(1'h1, 1'h1, b);
		step(1'h0, 1'h1, b);
		step(1'h0, 1'h1, b);
		scan(n, din, dout);
		step(1'h1, 1'h1, b);
		step(1'h0, 1'h1, b);
	endtask
	task automatic tlr();
		logic b;
		repeat (5) step(1'h1, 1'h1, b);
	endtask
	task automatic trst();
		@(posedge ref_clk_in);
		trst_n_out <= 1'h0;
		repeat (3) @(posedge ref_clk_in);
		trst_n_out <= 1'h1;
		@(posedge ref_clk_in);
	endtask
endmodule

//--- test/jib_top_tb_top.sv
// Testbench of the test access port block
`timescale 1ns/1ns
module jib_top_tb_top;
	import jib_pkg::*;
	localparam logic [31:0] ID_VAL = 32'h1357_9BDF; // Arbitrary identity value
	logic          ref_clk_in;
	logic          rst_n_in;
	jib_tap_pins_t pins;
	logic          trst_n;
	logic          tdo_out;
	logic          tdo_oe_out;
	wire           tdo_wire;
	logic [7:0]    bsr_pins_in;
	logic [7:0]    bsr_update_out;
	jib_pad_ctrl_t pad_ctrl_out;
	logic          leakage_out;
	logic [2:0]    test_ctrl_out;
	logic [6:0]    div_out;
	logic          erase_out;
	logic          lp_ok_out;
	logic          wb_cyc_in;
	logic          wb_stb_in;
	logic          wb_we_in;
	logic [7:0]    wb_adr_in;
	logic [3:0]    wb_sel_in;
	logic [31:0]   wb_dat_in;
	logic [31:0]   wb_dat_out;
	logic          wb_ack_out;
	int            error_cnt = 0;
	int            samples_checked = 0;
	jib_instr_t    codes [4] = '{INS_BYPASS, 4'h3, INS_HIGHZ, INS_CLAMP};
	logic [2:0]    pads [4] = '{3'h0, 3'h0, 3'h6, 3'h5};
	assign tdo_wire = tdo_oe_out ? tdo_out : 1'bz;
	always #5 ref_clk_in = ~ref_clk_in;
	jib_top #(.BSR_LEN(8), .ID_VALUE(ID_VAL)) i_jib_top (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .tap_pins_in(pins),
		.trst_n_in(trst_n), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
		.bsr_pins_in(bsr_pins_in), .bsr_update_out(bsr_update_out),
		.pad_ctrl_out(pad_ctrl_out), .leakage_out(leakage_out),
		.test_ctrl_out(test_ctrl_out), .flash_erase_clock_divider_out(div_out),
		.flash_erase_req_out(erase_out), .low_power_ok_out(lp_ok_out),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
	jib_tester i_jib_tester (.ref_clk_in(ref_clk_in), .tdo_in(tdo_wire), .pins_out(pins),
		.trst_n_out(trst_n));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge ref_clk_in);
		wb_cyc_in <= 1'h1;
		wb_stb_in <= 1'h1;
		wb_we_in <= we;
		wb_adr_in <= adr;
		wb_sel_in <= 4'hF;
		wb_dat_in <= wd;
		do @(posedge ref_clk_in); while (wb_ack_out !== 1'h1);
		rd = wb_dat_out;
		wb_cyc_in <= 1'h0;
		wb_stb_in <= 1'h0;
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		error_cnt++;
		wrap_up();
	end
	initial begin
		logic [31:0] d;
		logic [31:0] c;
		logic b;
		ref_clk_in = 1'h0;
		rst_n_in = 1'h0;
		bsr_pins_in = 8'hA5;
		wb_cyc_in = 1'h0;
		wb_stb_in = 1'h0;
		wb_we_in = 1'h0;
		wb_adr_in = 8'h00;
		wb_sel_in = 4'h0;
		wb_dat_in = 32'h0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'h1;
		wb(1'h0, OFS_IDCODE, 32'h0, d);
		chk("id reg", d, ID_VAL | 32'h1);
		wb(1'h0, 8'h0C, 32'h0, d);
		chk("unmapped", d, 32'h0);
		wb(1'h1, OFS_CTRL, 32'h1, d);
		wb(1'h0, OFS_STATUS, 32'h0, d);
		chk("state after reset", 32'(d[7:0]), 32'h10);
		chk("stop allowed", 32'(lp_ok_out), 32'h1);
		i_jib_tester.step(1'h0, 1'h1, b);
		chk("stop blocked", 32'(lp_ok_out), 32'h0);
		i_jib_tester.dr(32, 32'h0, d, 1'h0);
		chk("id scan", d, ID_VAL | 32'h1);
		$display("Test identity done");
		for (int i = 0; i < 4; i++) begin
			i_jib_tester.ir(codes[i], c, 1'h0);
			chk("ir capture", c, 32'h1);
			chk("pad ctrl", 32'(pad_ctrl_out), 32'(pads[i]));
			i_jib_tester.dr(2, 32'h3, d, 1'h0);
			chk("bypass", d, 32'h2);
		end
		$display("Test bypass codes done");
		i_jib_tester.ir(INS_SAMPLE, c, 1'h0);
		chk("sample pads", 32'(pad_ctrl_out), 32'h0);
		i_jib_tester.dr(8, 32'h3C, d, 1'h0);
		chk("sample capture", d, 32'hA5);
		chk("preload", 32'(bsr_update_out), 32'h3C);
		chk("tdo idle", 32'(tdo_oe_out), 32'h0);
		i_jib_tester.ir(INS_EXTEST, c, 1'h0);
		chk("extest pads", 32'(pad_ctrl_out), 32'h5);
		chk("cells kept", 32'(bsr_update_out), 32'h3C);
		$display("Test boundary done");
		i_jib_tester.ir(INS_TESTCTL, c, 1'h0);
		i_jib_tester.dr(3, 32'h5, d, 1'h0);
		chk("test ctrl", 32'(test_ctrl_out), 32'h5);
		i_jib_tester.tlr();
		wb(1'h0, OFS_STATUS, 32'h0, d);
		chk("five tms", 32'(d[3:0]), 32'h0);
		chk("test ctrl kept", 32'(test_ctrl_out), 32'h5);
		$display("Test control done");
		i_jib_tester.step(1'h0, 1'h1, b);
		i_jib_tester.ir(INS_LOCKOUT, c, 1'h1);
		chk("no early erase", 32'(erase_out), 32'h0);
		i_jib_tester.dr(7, 32'h5A, d, 1'h1);
		chk("divider", 32'(div_out), 32'h5A);
		chk("erase", 32'(erase_out), 32'h1);
		i_jib_tester.tlr();
		i_jib_tester.trst();
		rst_n_in <= 1'h0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'h1;
		@(posedge ref_clk_in);
		chk("chip reset", 32'(div_out), 32'(DIV_RST));
		chk("erase off", 32'(erase_out), 32'h0);
		$display("Test lockout done");
		i_jib_tester.step(1'h0, 1'h1, b);
		i_jib_tester.ir(INS_LEAKAGE, c, 1'h0);
		chk("leakage", 32'(leakage_out), 32'h1);
		i_jib_tester.tlr();
		wb(1'h0, OFS_STATUS, 32'h0, d);
		chk("leak stuck", 32'({d[8], d[3:0]}), 32'h11);
		i_jib_tester.trst();
		wb(1'h0, OFS_STATUS, 32'h0, d);
		chk("leak cleared", 32'({d[8], d[7:0]}), 32'h10);
		$display("Test leakage done");
		wrap_up();
	end
endmodule
bind jib_top jib_top_chk #(.BSR_LEN(BSR_LEN)) i_jib_top_chk (
	.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .tap_pins_in(tap_pins_in),
	.trst_n_in(trst_n_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
	.bsr_update_out(bsr_update_out), .leakage_out(leakage_out),
	.test_ctrl_out(test_ctrl_out),
	.flash_erase_clock_divider_out(flash_erase_clock_divider_out),
	.flash_erase_req_out(flash_erase_req_out), .low_power_ok_out(low_power_ok_out),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out));
